// [verilog/edps_map.svh]
// Purpose: offsets, field positions and reset values of the early depth / payload control block
// Assumes: 32-bit AHB-Lite register window, one aligned word per register
// Notes:   included by the design and the bench
`ifndef EDPS_MAP_SVH
`define EDPS_MAP_SVH

// register byte offsets
`define EDPS_CTRL_OFF    8'h00
`define EDPS_SHADED_OFF  8'h04
`define EDPS_CULLED_OFF  8'h08

// control field positions
`define EDPS_MODE_LSB    0
`define EDPS_SRCZ_BIT    2
`define EDPS_SRCW_BIT    3
`define EDPS_ZW_LSB      4
`define EDPS_BARY_LSB    6
`define EDPS_DISP_BIT    12
`define EDPS_CTRL_MSB    12

// reset values
`define EDPS_CTRL_RST    13'h0000
`define EDPS_CNT_RST     32'h0000_0000

`endif

// [verilog/edps_pkg.sv]
// Purpose: types shared by the early depth / payload control block
// Assumes: the map header supplies offsets and field positions
// Notes:   pixel carriers are packed structs
`default_nettype none

package edps_pkg;

  // early depth/stencil control field
  typedef enum logic [1:0] {
    early_test_default_mode,
    early_test_always_shade_mode,
    early_test_before_shader_mode,
    early_test_reserved_mode
  } edps_early_mode_t;

  // position z/w interpolation field
  typedef enum logic [1:0] {
    zw_eval_at_pixel,
    zw_eval_reserved,
    zw_eval_at_centroid,
    zw_eval_per_sample
  } edps_zw_mode_t;

  // pixel arriving from the rasterizer with its depth/stencil verdict
  typedef struct packed {
    logic        valid;
    logic        pre_pass;
    logic        ds_pass;
    logic [31:0] z_pixel;
    logic [31:0] z_centroid;
    logic [31:0] z_sample;
    logic [31:0] w_pixel;
    logic [31:0] w_centroid;
    logic [31:0] w_sample;
  } edps_pix_in_t;

  // decision and payload sent to the pixel shader dispatcher
  typedef struct packed {
    logic        valid;
    logic        shade;
    logic        early_test;
    logic        ds_write_early;
    logic        ignore_shader_depth;
    logic        drop;
    logic        depth_en;
    logic        w_en;
    logic [5:0]  bary_en;
    logic [31:0] z;
    logic [31:0] w;
  } edps_pix_out_t;

endpackage

`default_nettype wire

// [verilog/edps_ctrl.sv]
// Purpose: early depth/stencil ordering, shader payload enables and z/w interpolation select
// Assumes: one clock; rasterizer verdicts arrive on the same clock; AHB-Lite register access
// Notes:   one pixel per cycle, result one cycle later, no stall
//
// Added by the designer: the register addresses and the AHB-Lite interface to the registers.
`default_nettype none
`include "edps_map.svh"

module edps_ctrl
  import edps_pkg::*;
#(
  parameter int CNT_W = 32
) (
  // clock and reset
  input  wire logic          hclk,
  input  wire logic          hresetn,
  // ahb-lite slave
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output logic      [31:0]   hrdata,
  output logic               hreadyout,
  output logic               hresp,
  // pixel stream
  input  wire edps_pix_in_t  pix_in,
  output edps_pix_out_t      pix_out,
  // dispatch enable level for the shader dispatcher
  output logic               dispatch_en
);

  if (CNT_W < 1 || CNT_W > 32) begin : g_bad_cnt
    $error("CNT_W must lie in 1..32");
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus address phase capture

  logic                      wr_pend;
  logic                      rd_pend;
  logic [7:0]                addr_q;
  logic [`EDPS_CTRL_MSB:0]   ctrl;
  logic [CNT_W-1:0]          shaded_cnt;
  logic [CNT_W-1:0]          culled_cnt;
  logic                      take;

  assign take = hsel && htrans[1] && hready;

  // reads take one wait state so that hrdata comes from a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend   <= 1'b0;
      rd_pend   <= 1'b0;
      addr_q    <= 8'h00;
      hreadyout <= 1'b1;
    end else begin
      wr_pend <= take && hwrite;
      if (take) begin
        addr_q <= haddr[7:0];
      end
      if (take && !hwrite) begin
        rd_pend   <= 1'b1;
        hreadyout <= 1'b0;
      end else if (rd_pend) begin
        rd_pend   <= 1'b0;
        hreadyout <= 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= `EDPS_CTRL_RST;
    end else if (wr_pend && addr_q == `EDPS_CTRL_OFF) begin
      ctrl <= hwdata[`EDPS_CTRL_MSB:0];
    end
  end

  edps_early_mode_t early_mode;
  edps_zw_mode_t    zw_mode;
  logic             src_z_en;
  logic             src_w_en;
  logic [5:0]       bary_en;

  assign early_mode = edps_early_mode_t'(ctrl[`EDPS_MODE_LSB +: 2]);
  assign zw_mode    = edps_zw_mode_t'(ctrl[`EDPS_ZW_LSB +: 2]);
  assign src_z_en   = ctrl[`EDPS_SRCZ_BIT];
  assign src_w_en   = ctrl[`EDPS_SRCW_BIT];
  assign bary_en    = ctrl[`EDPS_BARY_LSB +: 6];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dispatch_en <= 1'b0;
    end else begin
      dispatch_en <= ctrl[`EDPS_DISP_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_pend) begin
      unique case (addr_q)
        `EDPS_CTRL_OFF:   hrdata <= {{(31 - `EDPS_CTRL_MSB){1'b0}}, ctrl};
        `EDPS_SHADED_OFF: hrdata <= 32'(shaded_cnt);
        `EDPS_CULLED_OFF: hrdata <= 32'(culled_cnt);
        default:          hrdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-pixel decision

  logic        next_shade;
  logic        next_early;
  logic        next_wr_early;
  logic        next_ign_z;
  logic [31:0] next_z;
  logic [31:0] next_w;

  always_comb begin
    next_shade    = 1'b0;
    next_early    = 1'b0;
    next_wr_early = 1'b0;
    next_ign_z    = 1'b0;
    unique case (early_mode)
      early_test_always_shade_mode: begin
        next_shade = pix_in.pre_pass;
      end
      early_test_before_shader_mode: begin
        next_early    = 1'b1;
        next_shade    = pix_in.pre_pass && pix_in.ds_pass;
        next_wr_early = pix_in.pre_pass && pix_in.ds_pass;
        next_ign_z    = 1'b1;
      end
      default: begin
        // reserved code 3 falls back to the default mode
        next_shade = pix_in.pre_pass && pix_in.ds_pass;
      end
    endcase
  end

  // evaluation point only; inclusion is decided by the enables
  always_comb begin
    unique case (zw_mode)
      zw_eval_at_centroid: begin
        next_z = pix_in.z_centroid;
        next_w = pix_in.w_centroid;
      end
      zw_eval_per_sample: begin
        next_z = pix_in.z_sample;
        next_w = pix_in.w_sample;
      end
      default: begin
        next_z = pix_in.z_pixel;
        next_w = pix_in.w_pixel;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pix_out <= '0;
    end else begin
      pix_out.valid               <= pix_in.valid;
      pix_out.shade               <= pix_in.valid && next_shade;
      pix_out.early_test          <= next_early;
      pix_out.ds_write_early      <= pix_in.valid && next_wr_early;
      pix_out.ignore_shader_depth <= next_ign_z;
      pix_out.drop                <= pix_in.valid && !next_shade;
      pix_out.depth_en            <= src_z_en;
      pix_out.w_en                <= src_w_en;
      pix_out.bary_en             <= bary_en;
      pix_out.z                   <= src_z_en ? next_z : 32'h0000_0000;
      pix_out.w                   <= src_w_en ? next_w : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // invocation and cull counters; a pixel event in the clear cycle counts from zero, leaving 1

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shaded_cnt <= CNT_W'(0);
    end else if (pix_in.valid && next_shade) begin
      if (wr_pend && addr_q == `EDPS_SHADED_OFF) begin
        shaded_cnt <= CNT_W'(1);
      end else begin
        shaded_cnt <= shaded_cnt + CNT_W'(1);
      end
    end else if (wr_pend && addr_q == `EDPS_SHADED_OFF) begin
      shaded_cnt <= CNT_W'(0);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      culled_cnt <= CNT_W'(0);
    end else if (pix_in.valid && !next_shade) begin
      if (wr_pend && addr_q == `EDPS_CULLED_OFF) begin
        culled_cnt <= CNT_W'(1);
      end else begin
        culled_cnt <= culled_cnt + CNT_W'(1);
      end
    end else if (wr_pend && addr_q == `EDPS_CULLED_OFF) begin
      culled_cnt <= CNT_W'(0);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  AST_DEFAULT_SKIPS_FAIL: assert property (@(posedge hclk) disable iff (!hresetn)
    (pix_in.valid && early_mode == early_test_default_mode && !pix_in.ds_pass) |=> !pix_out.shade)
    else $error("default mode shaded a failing pixel");

  AST_ALWAYS_SHADE_FAIL: assert property (@(posedge hclk) disable iff (!hresetn)
    (pix_in.valid && early_mode == early_test_always_shade_mode && pix_in.pre_pass && !pix_in.ds_pass)
    |=> pix_out.shade)
    else $error("always-shade mode skipped a failing pixel");

  AST_PRE_REMOVED_UNSHADED: assert property (@(posedge hclk) disable iff (!hresetn)
    (pix_in.valid && !pix_in.pre_pass) |=> (pix_out.drop && !pix_out.shade))
    else $error("pre-shader removed pixel was shaded");

  AST_EARLY_NO_SHADE_FAIL: assert property (@(posedge hclk) disable iff (!hresetn)
    (pix_in.valid && early_mode == early_test_before_shader_mode && !pix_in.ds_pass)
    |=> (!pix_out.shade && pix_out.early_test))
    else $error("early mode shaded a failing pixel");

  AST_EARLY_WRITE_COMMIT: assert property (@(posedge hclk) disable iff (!hresetn)
    (pix_in.valid && early_mode == early_test_before_shader_mode && pix_in.pre_pass && pix_in.ds_pass)
    |=> (pix_out.ds_write_early && pix_out.shade))
    else $error("early mode did not commit depth write");

  AST_EARLY_IGNORE_Z: assert property (@(posedge hclk) disable iff (!hresetn)
    pix_out.ignore_shader_depth == ($past(early_mode) == early_test_before_shader_mode))
    else $error("shader depth ignore flag wrong");

  AST_SRC_Z_PAYLOAD: assert property (@(posedge hclk) disable iff (!hresetn)
    (src_z_en && zw_mode == zw_eval_at_centroid) |=> (pix_out.depth_en && pix_out.z == $past(pix_in.z_centroid)))
    else $error("source depth not taken at centroid");

  AST_SRC_W_SAMPLE: assert property (@(posedge hclk) disable iff (!hresetn)
    (src_w_en && zw_mode == zw_eval_per_sample) |=> (pix_out.w_en && pix_out.w == $past(pix_in.w_sample)))
    else $error("source w not taken per sample");

  AST_ZW_PIXEL: assert property (@(posedge hclk) disable iff (!hresetn)
    (src_z_en && (zw_mode == zw_eval_at_pixel || zw_mode == zw_eval_reserved))
    |=> pix_out.z == $past(pix_in.z_pixel))
    else $error("pixel-centre depth not selected");

  AST_BARY_PASS: assert property (@(posedge hclk) disable iff (!hresetn)
    ##1 pix_out.bary_en == $past(bary_en))
    else $error("barycentric enables not forwarded");

  AST_SHADED_COUNT: assert property (@(posedge hclk) disable iff (!hresetn)
    (pix_in.valid && next_shade && !(wr_pend && addr_q == `EDPS_SHADED_OFF))
    |=> shaded_cnt == $past(shaded_cnt) + CNT_W'(1))
    else $error("invocation counter missed a shaded pixel");

  AST_READ_ONE_WAIT: assert property (@(posedge hclk) disable iff (!hresetn)
    (take && !hwrite) |=> !hreadyout ##1 hreadyout)
    else $error("read answer not after one wait state");

endmodule

`default_nettype wire

// [tb/edps_disp_model.sv]
// Purpose: shader dispatcher that consumes the decision stream
// Assumes: threads launch only while the dispatch enable level is high
// Notes:   counts launched threads for the bench
`default_nettype none

module edps_disp_model
  import edps_pkg::*;
(
  // clock and reset
  input  wire logic          hclk,
  input  wire logic          hresetn,
  // decision stream
  input  wire edps_pix_out_t pix_out,
  input  wire logic          dispatch_en,
  // launched thread count
  output int                 threads
);
  timeunit 1ns;
  timeprecision 1ps;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      threads <= 0;
    end else if (pix_out.valid && pix_out.shade && dispatch_en) begin
      threads <= threads + 1;
    end
  end
endmodule

`default_nettype wire

// [tb/early_depth_ps_payload_ctrl_tb_top.sv]
// Purpose: self-checking bench for the early depth / payload control block
// Assumes: hready follows hreadyout; one pixel per cycle
// Notes:   a reference model predicts every pixel and both counters
`default_nettype none
`include "edps_map.svh"

module early_depth_ps_payload_ctrl_tb_top
  import edps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic          hclk, hresetn, hsel, hwrite, hreadyout, hresp, dispatch_en;
  logic [31:0]   haddr, hwdata, hrdata, rd;
  logic [1:0]    htrans;
  logic [2:0]    hsize;
  logic [12:0]   c;
  logic [223:0]  rbuf;
  edps_pix_in_t  pix_in, p;
  edps_pix_out_t pix_out, e, exp_q[$];
  int            error_cnt, total_checks, cycles, threads, t0, n_shade, n_drop, seed;

  edps_ctrl u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pix_in(pix_in), .pix_out(pix_out), .dispatch_en(dispatch_en));

  edps_disp_model u_disp (.hclk(hclk), .hresetn(hresetn), .pix_out(pix_out), .dispatch_en(dispatch_en),
    .threads(threads));

  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task end_sim;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge hclk) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      error_cnt++;
      end_sim();
    end
  end

  task chk(input string n, input logic [95:0] g, input logic [95:0] ev);
    total_checks++;
    if (g !== ev) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, ev, g);
    end
  endtask

  task ahb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
    chk("hresp", 96'(hresp), 96'h0);
  endtask

  function automatic edps_pix_out_t predict(edps_pix_in_t x, logic [12:0] k);
    edps_pix_out_t o;
    o = '0;
    o.valid = x.valid;
    if (x.valid) begin
      o.shade = x.pre_pass && (k[1:0] == 2'h1 || x.ds_pass);
      o.drop = !o.shade;
      o.early_test = k[1:0] == 2'h2;
      o.ds_write_early = o.early_test && o.shade;
      o.ignore_shader_depth = o.early_test;
      o.depth_en = k[2];
      o.w_en = k[3];
      o.bary_en = k[11:6];
      o.z = k[5:4] == 2'h2 ? x.z_centroid : k[5:4] == 2'h3 ? x.z_sample : x.z_pixel;
      o.w = k[5:4] == 2'h2 ? x.w_centroid : k[5:4] == 2'h3 ? x.w_sample : x.w_pixel;
      if (!k[2]) o.z = '0;
      if (!k[3]) o.w = '0;
    end
    return o;
  endfunction

  // flags and the z/w enables are bits 77:70 of the carrier, barycentric enables and interpolated values the rest
  task cmp(input edps_pix_out_t x);
    if (!x.valid) chk("pix_out.valid", 96'(pix_out.valid), 96'(x.valid));
    else begin
      chk("pix_out flags", 96'(pix_out[77:70]), 96'(x[77:70]));
      chk("pix_out payload", 96'(pix_out[69:0]), 96'(x[69:0]));
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h8c5b;
    {error_cnt, total_checks, cycles} = '0;
    hresetn = 1'b0;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    pix_in = '0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk);
    chk("reset outputs", 96'({dispatch_en, hresp, hreadyout, pix_out}), 96'({2'b00, 1'b1, 78'h0}));
    ahb(8'h0c, 1'b0, 32'h0, rd);
    chk("unmapped read", 96'(rd), 96'h0);
    for (int m = 0; m < 3; m++) begin
      for (int z = 0; z < 3; z++) begin
        // software keeps dispatch enabled and avoids the reserved codes
        c = {1'b1, 6'($random(seed)), 2'(z == 0 ? 0 : z + 1), 2'($random(seed)), 2'(m)};
        ahb(`EDPS_CTRL_OFF, 1'b1, {19'h0, c}, rd);
        ahb(`EDPS_SHADED_OFF, 1'b1, $random(seed), rd);
        ahb(`EDPS_CULLED_OFF, 1'b1, $random(seed), rd);
        ahb(`EDPS_CTRL_OFF, 1'b0, 32'h0, rd);
        chk("ctrl", 96'(rd), 96'({19'h0, c}));
        chk("dispatch_en", 96'(dispatch_en), 96'(1'b1));
        {n_shade, n_drop} = '0;
        t0 = threads;
        for (int i = 0; i < 17; i++) begin
          for (int j = 0; j < 7; j++) rbuf = {rbuf[191:0], 32'($random(seed))};
          p = i < 16 ? rbuf[$bits(p)-1:0] : '0;
          @(posedge hclk);
          pix_in <= p;
          e = predict(p, c);
          exp_q.push_back(e);
          n_shade += 32'(e.shade);
          n_drop += 32'(e.drop);
          @(negedge hclk);
          if (exp_q.size() > 1) cmp(exp_q.pop_front());
        end
        void'(exp_q.pop_front());
        ahb(`EDPS_SHADED_OFF, 1'b0, 32'h0, rd);
        chk("shaded count", 96'(rd), 96'(n_shade));
        ahb(`EDPS_CULLED_OFF, 1'b0, 32'h0, rd);
        chk("dropped count", 96'(rd), 96'(n_drop));
        chk("threads", 96'(threads - t0), 96'(n_shade));
      end
    end
    end_sim();
  end
endmodule

`default_nettype wire
